// >>> src/fpfh_pkg.sv
// Shared types and constants for the coprocessor result forwarding and hazard block
`default_nettype none
package fpfh_pkg;
   localparam int unsigned FPFH_DATA_W    = 32;
   localparam int unsigned FPFH_REG_AW    = 3;
   // Pipeline depth of a two-cycle arithmetic op, counted in execute phases
   localparam int unsigned FPFH_EXEC_PH   = 3;
   localparam int unsigned FPFH_RST_SYNC  = 2;
   localparam logic        FPFH_VLD_RST   = 1'b0;
   localparam logic [31:0] FPFH_DATA_RST  = 32'h0000_0000;

   // Ops as seen entering the first execute phase
   typedef enum logic [2:0] {
      float_multiply_op,
      float_add_op,
      float_subtract_op,
      float_multiply_accumulate_op,
      float_to_unsigned_half_round_op,
      wide_register_move_op,
      fpfh_other_op
   } fpfh_op_t;

   // Destination of a register move out of the coprocessor
   typedef enum logic [2:0] {
      accumulator_register,
      product_register,
      multiplicand_register,
      extended_pointer_registers,
      float_result_register
   } fpfh_mdst_t;
endpackage
`default_nettype wire

// >>> src/fpfh_hold_reg.sv
// Result holding register with valid flag, load wins over clear
`default_nettype none
module fpfh_hold_reg
   import fpfh_pkg::*;
#(
   parameter int unsigned WIDTH = FPFH_DATA_W
)
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Control
   input  wire logic             load,
   input  wire logic             clear,
   input  wire logic [WIDTH-1:0] d,
   // State
   output logic      [WIDTH-1:0] q,
   output logic                  vld
);
   initial
   begin
      if (WIDTH < 1)
         $error("fpfh_hold_reg: WIDTH must be at least 1");
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         q <= '0;
      else if (load)
         q <= d;
   end

   // A load in the clearing cycle must not be lost
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         vld <= FPFH_VLD_RST;
      else if (load)
         vld <= 1'b1;
      else if (clear)
         vld <= 1'b0;
   end
endmodule
`default_nettype wire

// >>> src/fpfh_forward_ctrl.sv
// Forwarding and stall-safe hazard control for two-cycle coprocessor results
// Behaviour
// - Two-cycle results complete in third execute phase and forward to later readers.
// - Only multiply, add, subtract and multiply-accumulate are tracked as two-cycle ops.
// - Move source is compared with pending two-cycle destinations; a third-phase match forwards, an earlier one waits.
// - A stall in the third execute phase must not make forwarding late.
// - The stale-read guard flag counts only moves into core registers.
// - Coprocessor-to-coprocessor moves also get the forwarded value under any stall.
// - A stalled third phase never lets the move sample the old register value.
// - Without stall the move samples the forwarded result on entering its read phase.
`default_nettype none
module fpfh_forward_ctrl
   import fpfh_pkg::*;
#(
   parameter int unsigned DATA_W = FPFH_DATA_W,
   parameter int unsigned REG_AW = FPFH_REG_AW
)
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // Pipeline control
   input  wire logic              stall,
   // Op entering the first execute phase
   input  wire logic              op_valid,
   input  wire fpfh_op_t          op_code,
   input  wire logic [REG_AW-1:0] op_dest,
   // Arithmetic result present while the op sits in the third execute phase
   input  wire logic [DATA_W-1:0] e3_result,
   // Register move entering its second read phase
   input  wire logic              mov_valid,
   input  wire logic [REG_AW-1:0] mov_src,
   input  wire fpfh_mdst_t        mov_dst,
   input  wire logic [DATA_W-1:0] rf_rdata,
   output logic                   mov_wait,
   output logic                   mov_done_q,
   output logic      [DATA_W-1:0] mov_data_q,
   output logic                   stale_guard_q,
   // Write-back to the coprocessor register file
   output logic                   wb_valid_q,
   output logic      [REG_AW-1:0] wb_dest_q,
   output logic      [DATA_W-1:0] wb_data_q
);
   initial
   begin
      if (DATA_W != FPFH_DATA_W || REG_AW < 1 || REG_AW > 8)
         $error("fpfh_forward_ctrl: unsupported DATA_W or REG_AW");
   end

   logic [FPFH_RST_SYNC-1:0] rst_sync_q;
   logic                     rst_n;
   logic [FPFH_EXEC_PH:1]    e_vld_q;
   logic [REG_AW-1:0]        e_dst_q [FPFH_EXEC_PH:1];
   logic                     is_2p;
   logic                     m3;
   logic                     m12;
   logic                     take;
   logic                     held;
   logic                     hold_load;
   logic                     e3_leave;
   logic [DATA_W-1:0]        hold_q;
   logic [DATA_W-1:0]        fwd_data;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         rst_sync_q <= '0;
      else
         rst_sync_q <= {rst_sync_q[FPFH_RST_SYNC-2:0], 1'b1};
   end
   assign rst_n = rst_sync_q[FPFH_RST_SYNC-1];

   always_comb
   begin
      is_2p = (op_code == float_multiply_op) || (op_code == float_add_op)
              || (op_code == float_subtract_op)
              || (op_code == float_multiply_accumulate_op);
   end

   // Execute phase tracking; a stall freezes every phase
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         e_vld_q <= '0;
      else if (!stall)
         e_vld_q <= {e_vld_q[FPFH_EXEC_PH-1:1], op_valid && is_2p};
   end

   always_ff @(posedge clk)
   begin
      if (!stall)
      begin
         e_dst_q[1] <= op_dest;
         for (int i = 2; i <= FPFH_EXEC_PH; i++)
            e_dst_q[i] <= e_dst_q[i-1];
      end
   end

   // Capture the result only when the third phase stalls; the datapath
   // value may not survive the stall, which is exactly the late-forward window
   assign e3_leave  = e_vld_q[FPFH_EXEC_PH] && !stall;
   assign hold_load = e_vld_q[FPFH_EXEC_PH] && stall && !held;

   fpfh_hold_reg #(
      .WIDTH (DATA_W)
   ) u_hold (
      .clk   (clk),
      .rst_n (rst_n),
      .load  (hold_load),
      .clear (e3_leave),
      .d     (e3_result),
      .q     (hold_q),
      .vld   (held)
   );

   assign fwd_data = held ? hold_q : e3_result;

   // Source compare against completing and still-pending destinations
   always_comb
   begin
      m3  = e_vld_q[FPFH_EXEC_PH] && (e_dst_q[FPFH_EXEC_PH] == mov_src);
      m12 = 1'b0;
      for (int i = 1; i < FPFH_EXEC_PH; i++)
         m12 = m12 || (e_vld_q[i] && (e_dst_q[i] == mov_src));
   end

   // Interlock instead of reading stale data when software left too few slots
   assign mov_wait = mov_valid && m12;
   assign take     = mov_valid && !stall && !m12;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         mov_done_q <= FPFH_VLD_RST;
      else
         mov_done_q <= take;
   end

   // Forwarded result wins over the register file for every destination kind
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         mov_data_q <= FPFH_DATA_RST[DATA_W-1:0];
      else if (take)
         mov_data_q <= m3 ? fwd_data : rf_rdata;
   end

   // Flags a move into a core register that the stall fix rescued
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         stale_guard_q <= FPFH_VLD_RST;
      else
         stale_guard_q <= take && m3 && held && (mov_dst != float_result_register);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wb_valid_q <= FPFH_VLD_RST;
         wb_dest_q  <= '0;
         wb_data_q  <= FPFH_DATA_RST[DATA_W-1:0];
      end
      else
      begin
         wb_valid_q <= e3_leave;
         if (e3_leave)
         begin
            wb_dest_q <= e_dst_q[FPFH_EXEC_PH];
            wb_data_q <= fwd_data;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_fwd_no_stall: assert property (
      take && m3 && !held |=> mov_data_q == $past(e3_result))
      else $error("unstalled forward did not deliver the new result");

   chk_fwd_after_stall: assert property (
      take && m3 && held |=> mov_data_q == $past(hold_q))
      else $error("stalled forward did not deliver the held result");

   chk_hold_through_stall: assert property (
      held && stall |=> held && (hold_q == $past(hold_q)))
      else $error("held result lost during stall");

   chk_class_filter: assert property (
      op_valid && !stall && !is_2p |=> !e_vld_q[1])
      else $error("non two-cycle op tracked");

   chk_pending_blocks: assert property (
      mov_valid && m12 |-> mov_wait && !take ##1 !mov_done_q)
      else $error("move taken while its source is pending");

   chk_guard_cpu_only: assert property (
      stale_guard_q |-> $past(mov_dst) != float_result_register && $past(held))
      else $error("guard flag raised for a coprocessor destination");

   chk_fpu_move_fwd: assert property (
      take && m3 && mov_dst == float_result_register |=> mov_data_q == $past(fwd_data))
      else $error("coprocessor move missed the forwarded value");

   chk_phase_walk: assert property (
      op_valid && is_2p && !stall ##1 !stall ##1 !stall ##1 !stall
      |=> wb_valid_q && wb_dest_q == $past(op_dest, 4))
      else $error("two-cycle result not written back after third phase");

   chk_no_stale_take: assert property (
      mov_valid && stall |=> !mov_done_q)
      else $error("move sampled during a stall");

   cov_fwd_plain: cover property (take && m3 && !held);
   cov_fwd_stalled: cover property (hold_load ##[1:8] take && m3 && held);
   cov_interlock: cover property (mov_wait ##1 take);
endmodule
`default_nettype wire

// >>> dv/fpfh_core_model.sv
// Behavioural coprocessor register file that feeds the move path and takes the write-backs
`default_nettype none
module fpfh_core_model
   import fpfh_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Read port
   input  wire logic        mov_valid,
   input  wire logic [2:0]  mov_src,
   output logic      [31:0] rf_rdata,
   // Write-back port
   input  wire logic        wb_valid_q,
   input  wire logic [2:0]  wb_dest_q,
   input  wire logic [31:0] wb_data_q
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] rf [8];
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n)
         rf <= '{default: 32'h0};
      else if (wb_valid_q)
         rf[wb_dest_q] <= wb_data_q;
   // Unselected port shows inverted data so a stray sample never looks right
   assign rf_rdata = mov_valid ? rf[mov_src] : ~rf[mov_src];
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the coprocessor forwarding and hazard control
`default_nettype none
module tb
   import fpfh_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, reset_n, stall, op_valid, mov_valid;
   logic        mov_wait, mov_done_q, stale_guard_q, wb_valid_q;
   fpfh_op_t    op_code;
   fpfh_mdst_t  mov_dst;
   logic [2:0]  op_dest, mov_src, wb_dest_q;
   logic [31:0] e3_result, rf_rdata, mov_data_q, wb_data_q, lfsr_q;
   logic [31:0] shadow [8];
   logic [32:0] exp_q [$];
   int          failures, total_checks, cycles;

   fpfh_forward_ctrl fpfh_forward_ctrl_i (.clk, .reset_n, .stall, .op_valid, .op_code,
      .op_dest, .e3_result, .mov_valid, .mov_src, .mov_dst, .rf_rdata, .mov_wait,
      .mov_done_q, .mov_data_q, .stale_guard_q, .wb_valid_q, .wb_dest_q, .wb_data_q);
   fpfh_core_model fpfh_core_model_i (.clk, .reset_n, .mov_valid, .mov_src, .rf_rdata,
      .wb_valid_q, .wb_dest_q, .wb_data_q);

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      if (failures == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // One op, a delay slot and an alignment cycle, then the dependent move
   task automatic run(input fpfh_op_t oc, input int ns, input logic early);
      logic [31:0] r;
      logic        trk;
      fpfh_mdst_t  md;
      lfsr_q = lfsr_next(lfsr_q);
      r = lfsr_q;
      md = fpfh_mdst_t'(r[31:29] % 3'd5);
      trk = (oc <= float_multiply_accumulate_op);
      op_valid <= 1'b1;
      op_code <= oc;
      op_dest <= r[2:0];
      @(posedge clk);
      op_valid <= 1'b0;
      @(posedge clk);
      // Early move meets the op in phase two and must be held off
      if (early)
      begin
         mov_valid <= 1'b1;
         mov_src <= r[2:0];
         @(posedge clk);
         check(33'(mov_wait), 33'h1);
      end
      else
         @(posedge clk);
      e3_result <= r;
      mov_valid <= 1'b1;
      mov_src <= r[2:0];
      mov_dst <= md;
      stall <= (ns > 0);
      exp_q.push_back({trk && ns > 0 && md != float_result_register,
                       trk ? r : shadow[r[2:0]]});
      if (trk)
         shadow[r[2:0]] = r;
      for (int i = 1; i <= ns; i++)
      begin
         @(posedge clk);
         // Live result is wiped so only a held copy can still be right
         e3_result <= ~r;
         stall <= (i < ns);
      end
      @(posedge clk);
      check(33'(mov_wait), 33'h0);
      mov_valid <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Result watcher pairs every completed move with the oldest note
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles > 1000)
      begin
         failures++;
         complete_run();
      end
      if (mov_done_q === 1'b1)
         check({stale_guard_q, mov_data_q}, exp_q.pop_front());
   end

   initial
   begin
      reset_n = 1'b0;
      stall = 1'b0;
      op_valid = 1'b0;
      op_code = fpfh_other_op;
      op_dest = 3'h0;
      e3_result = 32'h0;
      mov_valid = 1'b0;
      mov_src = 3'h0;
      mov_dst = accumulator_register;
      lfsr_q = 32'h1149a015;
      failures = 0;
      total_checks = 0;
      cycles = 0;
      shadow = '{default: 32'h0};
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      for (int o = 0; o < 7; o++)
         for (int ns = 0; ns < 4; ns++)
            run(fpfh_op_t'(o), ns, 1'b0);
      for (int o = 0; o < 4; o++)
         run(fpfh_op_t'(o), 0, 1'b1);
      check(33'(exp_q.size()), 33'h0);
      complete_run();
   end
endmodule
`default_nettype wire
